// *** hw/lcd_pkg.sv ***
// Contract
// - Resistor or capacitor variant fixed by non-volatile option input, not register.
// - Capacitor variant: type select picks capacitor bias or regulator drive.
// - No display output unless display_on is set.
// - Duty bit picks 1/4 or 1/5 duty, both 1/3 bias.
// - Idle/power-down on high RC keeps display running, except stop on single-clock options; otherwise driver off.
// - Power-on, pin, low-voltage and watchdog resets switch driver off.
// - Display off drives every common and segment low.
// - Crystal option clocks display from crystal at fixed 64 Hz frame.
// - Low RC at 32 kHz gives fixed 64 Hz; divider register ignored.
// - Low RC at 128 kHz: divider picks 1/4..1/1 of 256 Hz frame.
// - Single high-frequency clock option uses 128 kHz RC for display.
// - Stop halts display clock on single-clock options or dual-clock low running.
// - Idle mode keeps display clock running only while on high RC clock.
// - 4/5 commons and 32/31 segments, each shareable as I/O by share selects.
// - 32-byte display RAM at 500H-51FH, usable as data memory.
// - Resistor mode: two-bit field selects 60K, 900K or 1.5M bias.
// - Fast charge uses 60K during refresh, then 900K/1.5M for remainder.
// - Fast charge interval 1/8, 1/16, 1/32 or 1/64 of common period.
// - P0.2-P0.6 are pump pins only with capacitor variant and pump on.
// - display_on 0 disables, 1 enables; duty 0 is 1/4, 1 is 1/5.
// - Type select 0 capacitor, 1 regulator; both work only with pump on.
// - Fast charge code 00=1/8, 01=1/16, 10=1/32, 11=1/64.
package lcd_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [11:0] LCD_OFS_CTRL   = 12'h000;
  localparam logic [11:0] LCD_OFS_CTRL1  = 12'h004;
  localparam logic [11:0] LCD_OFS_CLKDIV = 12'h008;
  localparam logic [11:0] LCD_OFS_SHARE0 = 12'h00c;
  localparam logic [11:0] LCD_OFS_SHARE1 = 12'h010;
  localparam logic [11:0] LCD_OFS_STATUS = 12'h014;
  localparam logic [11:0] LCD_OFS_RAM    = 12'h500;
  localparam logic [11:0] LCD_OFS_RAM_END = 12'h51f;
  localparam int          LCD_RAM_BYTES  = 32;

  // Field positions in display_control
  localparam int LCD_B_ON    = 7;
  localparam int LCD_B_PUMP  = 6;
  localparam int LCD_B_DUTY  = 5;
  localparam int LCD_B_TYPE  = 4;
  // Field positions in display_control_one
  localparam int LCD_B_FC    = 4;
  localparam int LCD_B_MOD   = 0;

  localparam logic [7:0] LCD_CTRL_RST  = 8'h00;
  localparam logic [7:0] LCD_CTRL1_MSK = 8'h37;
  localparam logic [1:0] LCD_CLKDIV_RST = 2'h0;

  // Bias resistor codes
  localparam logic [1:0] LCD_MOD_60K  = 2'h1;
  localparam logic [1:0] LCD_MOD_FC   = 2'h0;

  // Oscillator option codes
  localparam logic [3:0] LCD_OSC_HF_A = 4'h0;
  localparam logic [3:0] LCD_OSC_HF_B = 4'hf;

  // Frame timing: 256 Hz base from 128 kHz RC, 64 Hz fixed from 32 kHz sources
  localparam int LCD_FRAME_BASE_HZ  = 256;
  localparam int LCD_FRAME_FIXED_HZ = 64;
  localparam int LCD_CLK_HZ         = 50000000;
  localparam int LCD_SLOTS_PER_FRAME_MAX = 5;

  localparam logic [1:0] LCD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LCD_RESP_SLVERR = 2'h2;

  // Low-frequency source select for the frame clock
  typedef enum logic [1:0]
  {
    LCD_SRC_XTAL  = 2'h0,
    LCD_SRC_RC32  = 2'h1,
    LCD_SRC_RC128 = 2'h3
  } lcd_src_t;

  // Low-power state of the processor
  typedef enum logic [1:0]
  {
    LCD_PM_RUN  = 2'h0,
    LCD_PM_IDLE = 2'h1,
    LCD_PM_STOP = 2'h3
  } lcd_pm_t;

  // Chip reset causes
  typedef struct packed
  {
    logic power_on;
    logic pin;
    logic low_voltage_reset;
    logic watchdog_reset;
  } lcd_rst_src_t;

  // Non-volatile configuration straps
  typedef struct packed
  {
    logic       driver_variant_option;
    logic [3:0] oscillator_option;
    logic       low_rc_is_128k;
    logic       crystal_selected;
  } lcd_opt_t;

endpackage : lcd_pkg

// *** hw/lcd_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module lcd_sync
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] sh_q;
  logic       out_q;

  // First stage is read only by the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_q  <= 3'h0;
      out_q <= 1'b0;
    end
    else
    begin
      sh_q <= {sh_q[1:0], din};
      if (sh_q[1] == sh_q[2])
        out_q <= sh_q[2];
    end
  end

  assign dout = out_q;
endmodule : lcd_sync

// *** hw/lcd_tick.sv ***
`timescale 1ns/1ps
// Slot tick generator: pulses once per common slot at the chosen frame rate
module lcd_tick
#(
  parameter int CLK_HZ = 50000000
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  input  wire logic [15:0] frame_hz,
  input  wire logic [2:0]  slots,
  output logic             tick
);
  logic [31:0] acc_q;
  logic        tick_q;
  wire  [31:0] step = 32'(frame_hz) * 32'(slots);
  wire  [32:0] sum  = {1'b0, acc_q} + {1'b0, step};

  // Fractional accumulator avoids drift at odd frame rates like 85 Hz (256/3 truncated)
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      acc_q  <= 32'h0;
      tick_q <= 1'b0;
    end
    else if (sum >= 33'(CLK_HZ))
    begin
      acc_q  <= 32'(sum - 33'(CLK_HZ));
      tick_q <= 1'b1;
    end
    else
    begin
      acc_q  <= sum[31:0];
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;
endmodule : lcd_tick

// *** hw/lcd_ctrl.sv ***
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Segment LCD driver controller with AXI4-Lite register slave
module lcd_ctrl
#(
  parameter int NCOM = 5,
  parameter int NSEG = 32
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire lcd_pkg::lcd_opt_t    options,
  input  wire lcd_pkg::lcd_rst_src_t reset_cause,
  input  wire lcd_pkg::lcd_pm_t     power_mode,
  input  wire logic                 high_rc_clock,
  input  wire logic                 low_clk_pin,
  output logic [NCOM-1:0]           com_out,
  output logic [NSEG-1:0]           seg_out,
  output logic [NCOM+NSEG-1:0]      pin_is_lcd,
  output logic [4:0]                pump_pin_en,
  output logic                      pump_enable,
  output logic                      regulator_enable,
  output logic                      cap_bias_enable,
  output logic [1:0]                bias_resistor,
  output logic [3:0]                contrast
);

  // Registers
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl1_q;
  logic [1:0]  clkdiv_q;
  logic [31:0] share0_q;
  logic [31:0] share1_q;
  logic [7:0]  ram_q [lcd_pkg::LCD_RAM_BYTES];
  logic [2:0]  slot_q;
  logic [5:0]  sub_q;
  logic [NCOM-1:0] com_q;
  logic [NSEG-1:0] seg_q;
  logic        fc_q;

  // Write and read channel state
  logic        aw_have_q;
  logic        w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // Control fields
  wire       disp_on   = ctrl_q[lcd_pkg::LCD_B_ON];
  wire       pump_on   = ctrl_q[lcd_pkg::LCD_B_PUMP];
  wire       duty5     = ctrl_q[lcd_pkg::LCD_B_DUTY];
  wire       type_reg  = ctrl_q[lcd_pkg::LCD_B_TYPE];
  wire [1:0] fc_time   = ctrl1_q[lcd_pkg::LCD_B_FC +: 2];
  wire [1:0] bias_sel  = ctrl1_q[lcd_pkg::LCD_B_MOD +: 2];
  wire       cap_var   = options.driver_variant_option;

  // Any chip reset source also clears the control state
  wire any_rst = reset_cause.power_on | reset_cause.pin
               | reset_cause.low_voltage_reset | reset_cause.watchdog_reset;
  wire srst    = !aresetn || any_rst;

  // Low-power gating: idle/stop keep running only on high RC clock
  logic hrc_s;
  logic lowclk_s;
  lcd_sync u_hrc_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (high_rc_clock),
    .dout    (hrc_s)
  );
  // Raw low clock pin level is synchronised only as a liveness indicator
  lcd_sync u_low_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (low_clk_pin),
    .dout    (lowclk_s)
  );

  wire single_hf = (options.oscillator_option == lcd_pkg::LCD_OSC_HF_A)
                 || (options.oscillator_option == lcd_pkg::LCD_OSC_HF_B);
  // Stop halts the display clock for single-HF, or for dual clock while on low clock
  wire stop_halt = (power_mode == lcd_pkg::LCD_PM_STOP) && (single_hf || !hrc_s);
  // Idle halts the display clock unless running on the high RC clock
  wire idle_kill = (power_mode == lcd_pkg::LCD_PM_IDLE) && !hrc_s;
  wire clk_run   = !stop_halt;
  wire active    = disp_on && clk_run && !idle_kill;

  // Frame source selection from the oscillator straps
  lcd_pkg::lcd_src_t src;
  assign src = single_hf ? lcd_pkg::LCD_SRC_RC128
             : options.crystal_selected ? lcd_pkg::LCD_SRC_XTAL
             : options.low_rc_is_128k ? lcd_pkg::LCD_SRC_RC128
             : lcd_pkg::LCD_SRC_RC32;

  // 128 kHz RC: 256 Hz divided by 4,3,2,1 for codes 0..3
  wire [15:0] div_hz  = 16'(lcd_pkg::LCD_FRAME_BASE_HZ / (4 - int'(clkdiv_q)));
  wire [15:0] frame_hz = (src == lcd_pkg::LCD_SRC_RC128) ? div_hz
                       : 16'(lcd_pkg::LCD_FRAME_FIXED_HZ);
  wire [2:0]  slots   = duty5 ? 3'h5 : 3'h4;

  // Each slot is split into 64 sub-steps to time fast charge
  logic sub_tick;
  lcd_tick #(.CLK_HZ(lcd_pkg::LCD_CLK_HZ * 1)) u_tick
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (active),
    .frame_hz (16'(frame_hz * 16'h40)),
    .slots    (slots),
    .tick     (sub_tick)
  );

  // Slot and sub-step counters
  always_ff @(posedge aclk)
  begin
    if (srst || !active)
    begin
      slot_q <= 3'h0;
      sub_q  <= 6'h0;
    end
    else if (sub_tick)
    begin
      sub_q <= sub_q + 6'h1;
      if (sub_q == 6'h3f)
        slot_q <= (slot_q + 3'h1 >= slots) ? 3'h0 : slot_q + 3'h1;
    end
  end

  // Fast charge window: first 8,4,2 or 1 of 64 sub-steps of each slot
  wire [5:0] fc_len = 6'h8 >> fc_time;
  wire fc_mode = (bias_sel == lcd_pkg::LCD_MOD_FC) || bias_sel[1];
  wire in_fc   = (sub_q < fc_len);

  // Common and segment drive; all low while off
  always_ff @(posedge aclk)
  begin
    if (srst || !active)
    begin
      com_q <= '0;
      seg_q <= '0;
      fc_q  <= 1'b0;
    end
    else
    begin
      com_q <= NCOM'(1) << slot_q;
      for (int s = 0; s < NSEG; s++)
        seg_q[s] <= ram_q[s][slot_q];
      fc_q <= fc_mode && in_fc;
    end
  end

  // Duty 1/4 frees the fifth common, which then serves as the last segment
  assign com_out = com_q;
  assign seg_out = duty5 ? {1'b0, seg_q[NSEG-2:0]} : seg_q;

  // Pin share: a pin is LCD only when its share select bit is set
  genvar gp;
  generate
    for (gp = 0; gp < NCOM + NSEG; gp++)
    begin : g_share
      if (gp < 32)
        assign pin_is_lcd[gp] = share0_q[gp];
      else
        assign pin_is_lcd[gp] = share1_q[gp-32];
    end
  endgenerate

  // Pump and regulator only with capacitor variant fixed by strap
  assign pump_enable      = cap_var && pump_on;
  assign pump_pin_en      = {5{cap_var && pump_on}};
  assign cap_bias_enable  = pump_enable && !type_reg;
  assign regulator_enable = pump_enable && type_reg;
  // Resistor choice: 60K during fast charge, else the selected high value
  assign bias_resistor    = cap_var ? 2'h0 : (fc_q ? lcd_pkg::LCD_MOD_60K : bias_sel);
  assign contrast         = ctrl_q[3:0];

  // AXI write side: address and data accepted in either order
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire ram_hit_w = (aw_addr_q >= lcd_pkg::LCD_OFS_RAM) && (aw_addr_q <= lcd_pkg::LCD_OFS_RAM_END);
  wire [4:0] ram_idx_w = 5'(aw_addr_q - lcd_pkg::LCD_OFS_RAM);
  wire reg_hit_w = (aw_addr_q == lcd_pkg::LCD_OFS_CTRL) || (aw_addr_q == lcd_pkg::LCD_OFS_CTRL1)
                 || (aw_addr_q == lcd_pkg::LCD_OFS_CLKDIV) || (aw_addr_q == lcd_pkg::LCD_OFS_SHARE0)
                 || (aw_addr_q == lcd_pkg::LCD_OFS_SHARE1) || (aw_addr_q == lcd_pkg::LCD_OFS_STATUS);
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 12'h0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= lcd_pkg::LCD_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (ram_hit_w || reg_hit_w) ? lcd_pkg::LCD_RESP_OKAY : lcd_pkg::LCD_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Control registers; chip reset causes clear them, share selects too
  always_ff @(posedge aclk)
  begin
    if (srst)
    begin
      ctrl_q   <= lcd_pkg::LCD_CTRL_RST;
      ctrl1_q  <= 8'h00;
      clkdiv_q <= lcd_pkg::LCD_CLKDIV_RST;
      share0_q <= 32'h0;
      share1_q <= 32'h0;
    end
    else if (do_write && w_strb_q[0])
    begin
      if (aw_addr_q == lcd_pkg::LCD_OFS_CTRL)
        ctrl_q <= w_data_q[7:0];
      if (aw_addr_q == lcd_pkg::LCD_OFS_CTRL1)
        ctrl1_q <= w_data_q[7:0] & lcd_pkg::LCD_CTRL1_MSK;
      if (aw_addr_q == lcd_pkg::LCD_OFS_CLKDIV)
        clkdiv_q <= w_data_q[1:0];
      if (aw_addr_q == lcd_pkg::LCD_OFS_SHARE0)
        share0_q <= w_data_q;
      if (aw_addr_q == lcd_pkg::LCD_OFS_SHARE1)
        share1_q <= w_data_q;
    end
  end

  // Display RAM: one byte per byte address, kept through resets like ordinary memory
  genvar gr;
  generate
    for (gr = 0; gr < lcd_pkg::LCD_RAM_BYTES; gr++)
    begin : g_ram
      always_ff @(posedge aclk)
      begin
        if (do_write && ram_hit_w && w_strb_q[0] && ram_idx_w == 5'(gr))
          ram_q[gr] <= w_data_q[7:0];
      end
    end
  endgenerate

  // Read side: one cycle to answer, held until rready
  wire ram_hit_r = (s_axi_araddr >= lcd_pkg::LCD_OFS_RAM) && (s_axi_araddr <= lcd_pkg::LCD_OFS_RAM_END);
  wire [4:0] ram_idx_r = 5'(s_axi_araddr - lcd_pkg::LCD_OFS_RAM);
  wire [31:0] status_w = {24'h0, fc_q, cap_var, lowclk_s, hrc_s, active, slot_q};
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= lcd_pkg::LCD_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= lcd_pkg::LCD_RESP_OKAY;
      unique case (s_axi_araddr)
        lcd_pkg::LCD_OFS_CTRL:   rdata_q <= {24'h0, ctrl_q};
        lcd_pkg::LCD_OFS_CTRL1:  rdata_q <= {24'h0, ctrl1_q};
        lcd_pkg::LCD_OFS_CLKDIV: rdata_q <= {30'h0, clkdiv_q};
        lcd_pkg::LCD_OFS_SHARE0: rdata_q <= share0_q;
        lcd_pkg::LCD_OFS_SHARE1: rdata_q <= share1_q;
        lcd_pkg::LCD_OFS_STATUS: rdata_q <= status_w;
        default:
        begin
          rdata_q <= ram_hit_r ? {24'h0, ram_q[ram_idx_r]} : 32'h0;
          rresp_q <= ram_hit_r ? lcd_pkg::LCD_RESP_OKAY : lcd_pkg::LCD_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : lcd_ctrl

// *** sim/lcd_ctrl_assertions.sv ***
`timescale 1ns/1ps
// Port-level checks on the display controller; watches its ports only, inputs and outputs
module lcd_ctrl_assertions
#(
  parameter int NCOM = 5,
  parameter int NSEG = 32
)
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [11:0]           s_axi_araddr,
  input wire logic                  s_axi_rvalid,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic [31:0]           s_axi_rdata,
  input wire lcd_pkg::lcd_opt_t     options,
  input wire lcd_pkg::lcd_rst_src_t reset_cause,
  input wire lcd_pkg::lcd_pm_t      power_mode,
  input wire logic                  high_rc_clock,
  input wire logic [NCOM-1:0]       com_out,
  input wire logic [NSEG-1:0]       seg_out,
  input wire logic [4:0]            pump_pin_en,
  input wire logic                  pump_enable,
  input wire logic                  regulator_enable,
  input wire logic                  cap_bias_enable,
  input wire logic [1:0]            bias_resistor
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Steps that start the multi-cycle checks
  sequence s_cause;
    |reset_cause;
  endsequence
  sequence s_bad_ar;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hffc;
  endsequence

  property p_off_low;
    com_out == '0 |-> seg_out == '0;
  endproperty
  a_off_low: assert property (p_off_low) else $error("segments driven while commons idle");
  property p_one_com;
    $onehot0(com_out);
  endproperty
  a_one_com: assert property (p_one_com) else $error("more than one common active");
  property p_seg_last;
    com_out[NCOM-1] |-> !seg_out[NSEG-1];
  endproperty
  a_seg_last: assert property (p_seg_last) else $error("last segment driven in fifth slot");
  // Registers and the drive flops both clear on the first edge after the cause
  property p_cause_off;
    s_cause |-> ##[2:4] (com_out == '0 && !pump_enable);
  endproperty
  a_cause_off: assert property (p_cause_off) else $error("driver still on after chip reset");
  property p_pump_pins;
    $stable(options) |-> ((pump_pin_en != 5'h00) == (pump_enable && options.driver_variant_option));
  endproperty
  a_pump_pins: assert property (p_pump_pins) else $error("pump pins disagree with pump and variant");
  property p_reg_path;
    regulator_enable |-> pump_enable && !cap_bias_enable;
  endproperty
  a_reg_path: assert property (p_reg_path) else $error("regulator without pump or with cap bias");
  property p_cap_res;
    options.driver_variant_option [*2] |-> bias_resistor == 2'h0;
  endproperty
  a_cap_res: assert property (p_cap_res) else $error("bias resistor active in capacitor variant");
  // Synchroniser delay on the RC flag is why the window is eight cycles
  property p_idle_off;
    (power_mode == lcd_pkg::LCD_PM_IDLE && !high_rc_clock) [*8] |-> com_out == '0;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("display on in idle without high RC");
  property p_stop_off;
    (power_mode == lcd_pkg::LCD_PM_STOP && (options.oscillator_option == lcd_pkg::LCD_OSC_HF_A
      || options.oscillator_option == lcd_pkg::LCD_OSC_HF_B)) [*4] |-> com_out == '0;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("display on in stop with single clock");
  property p_err_read;
    s_bad_ar |=> s_axi_rvalid && s_axi_rresp == lcd_pkg::LCD_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_err_read: assert property (p_err_read) else $error("unmapped read not refused");
endmodule : lcd_ctrl_assertions

// *** sim/lcd_panel_model.sv ***
`timescale 1ns/1ps
// Passive glass: reports which common is energised and the segments seen
module lcd_panel_model
(
  input  wire logic [4:0]  com_out,
  input  wire logic [31:0] seg_out,
  output logic [2:0]       slot,
  output logic [31:0]      seg_seen
);
  // Glass holds no state; 7 means no common energised
  always_comb
  begin
    slot = 3'h7;
    for (int i = 0; i < 5; i++)
      if (com_out[i])
        slot = 3'(i);
    seg_seen = seg_out;
  end
endmodule : lcd_panel_model

// *** sim/tb_lcd_ctrl.sv ***
`timescale 1ns/1ps
module tb_lcd_ctrl;
  logic                  aclk = 1'b0;
  logic                  aresetn;
  logic [11:0]           awaddr, araddr;
  logic [31:0]           wdata;
  logic                  awvalid, wvalid, bready, arvalid, rready;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp, bias_resistor;
  logic [31:0]           rdata, seg_out, seg_seen;
  lcd_pkg::lcd_opt_t     options;
  lcd_pkg::lcd_rst_src_t reset_cause;
  lcd_pkg::lcd_pm_t      power_mode;
  logic                  high_rc_clock, low_clk_pin, pump_enable, regulator_enable, cap_bias_enable;
  logic [4:0]            com_out, pump_pin_en;
  logic [2:0]            slot, prev;
  logic [7:0]            ram [32];
  logic [33:0]           exp_q [$];
  logic [33:0]           note;
  int                    miscompares = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;

  always #10 aclk = ~aclk;

  lcd_ctrl u_lcd_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .options(options),
    .reset_cause(reset_cause), .power_mode(power_mode), .high_rc_clock(high_rc_clock),
    .low_clk_pin(low_clk_pin), .com_out(com_out), .seg_out(seg_out), .pin_is_lcd(),
    .pump_pin_en(pump_pin_en), .pump_enable(pump_enable), .regulator_enable(regulator_enable),
    .cap_bias_enable(cap_bias_enable), .bias_resistor(bias_resistor), .contrast());
  lcd_panel_model u_lcd_panel_model (.com_out(com_out), .seg_out(seg_out), .slot(slot), .seg_seen(seg_seen));

  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED bus t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bus

  task automatic cmp_pin(input logic [36:0] got, input logic [36:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED pin t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_pin

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Each channel is released at the edge that takes it; ready is read mid-cycle
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_x, w_x, b_x;
    exp_q.push_back({er, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_x)
    begin
      @(negedge aclk);
      aw_x = awvalid && awready;
      w_x = wvalid && wready;
      b_x = bvalid;
      @(posedge aclk);
      if (aw_x)
        awvalid <= 1'b0;
      if (w_x)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
    bit a_x, r_x;
    exp_q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_x)
    begin
      @(negedge aclk);
      a_x = arvalid && arready;
      r_x = rvalid;
      @(posedge aclk);
      if (a_x)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd

  task automatic settle_pins;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
  endtask : settle_pins

  // Segment s in slot k shows bit k of its byte; the last one is a common at 1/5 duty
  function automatic logic [31:0] seg_exp(input logic [2:0] k);
    logic [31:0] e;
    for (int s = 0; s < 32; s++)
      e[s] = ram[s][k];
    e[31] = 1'b0;
    return e;
  endfunction : seg_exp

  // Bus results are matched against the oldest note
  always @(negedge aclk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      note = exp_q.pop_front();
      cmp_bus(bvalid ? {bresp, 32'h0} : {rresp, rdata}, note);
    end
  end

  // Hang guard; the slot waits dominate the run time
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    options = '{1'b0, 4'h3, 1'b1, 1'b0};
    reset_cause = '0;
    power_mode = lcd_pkg::LCD_PM_RUN;
    high_rc_clock = 1'b1;
    void'($urandom(82079));
    low_clk_pin = 1'($urandom);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++)
      axi_rd(12'(4 * i), 34'h0);
    axi_wr(12'hffc, 32'h1, lcd_pkg::LCD_RESP_SLVERR);
    axi_rd(12'hffc, {lcd_pkg::LCD_RESP_SLVERR, 32'h0});
    axi_wr(12'h004, 32'hff, lcd_pkg::LCD_RESP_OKAY);
    axi_rd(12'h004, {lcd_pkg::LCD_RESP_OKAY, 32'h37});
    // Capacitor variant: both drive types, pump and type select set in one write with the display off
    options.driver_variant_option <= 1'b1;
    for (int t = 0; t < 2; t++)
    begin
      axi_wr(12'h000, 32'h40 | (t << 4), lcd_pkg::LCD_RESP_OKAY);
      settle_pins();
      cmp_pin({29'h0, pump_pin_en, pump_enable, regulator_enable, cap_bias_enable}, {29'h0, 5'h1f, 1'b1, 1'(t), 1'(!t)});
    end
    options.driver_variant_option <= 1'b0;
    axi_wr(12'h004, 32'h1, lcd_pkg::LCD_RESP_OKAY);
    settle_pins();
    cmp_pin({30'h0, pump_pin_en, bias_resistor}, {30'h0, 5'h0, 2'h1});
    // Every chip reset cause clears the control word
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(12'h000, 32'hc0, lcd_pkg::LCD_RESP_OKAY);
      @(posedge aclk);
      reset_cause <= 4'h1 << i;
      @(posedge aclk);
      reset_cause <= '0;
      axi_rd(12'h000, 34'h0);
    end
    for (int s = 0; s < 32; s++)
    begin
      ram[s] = 8'($urandom);
      axi_wr(12'h500 + 12'(s), {24'h0, ram[s]}, lcd_pkg::LCD_RESP_OKAY);
    end
    axi_rd(12'h51f, {lcd_pkg::LCD_RESP_OKAY, 24'h0, ram[31]});
    axi_wr(12'h008, 32'h3, lcd_pkg::LCD_RESP_OKAY);
    axi_wr(12'h000, 32'ha0, lcd_pkg::LCD_RESP_OKAY);
    // First lit slot, then the next one
    for (int k = 0; k < 2; k++)
    begin
      prev = slot;
      while (slot === prev)
        @(posedge aclk);
      @(negedge aclk);
      cmp_pin({5'h0, seg_seen}, {5'h0, seg_exp(slot)});
    end
    power_mode <= lcd_pkg::LCD_PM_IDLE;
    settle_pins();
    cmp_pin({36'h0, |com_out}, 37'h1);
    high_rc_clock <= 1'b0;
    settle_pins();
    cmp_pin({com_out, seg_out}, 37'h0);
    high_rc_clock <= 1'b1;
    options.oscillator_option <= lcd_pkg::LCD_OSC_HF_A;
    power_mode <= lcd_pkg::LCD_PM_STOP;
    settle_pins();
    cmp_pin({com_out, seg_out}, 37'h0);
    power_mode <= lcd_pkg::LCD_PM_RUN;
    axi_wr(12'h000, 32'h20, lcd_pkg::LCD_RESP_OKAY);
    settle_pins();
    cmp_pin({com_out, seg_out}, 37'h0);
    tally_and_finish();
  end
endmodule : tb_lcd_ctrl

bind lcd_ctrl lcd_ctrl_assertions #(.NCOM(NCOM), .NSEG(NSEG)) u_lcd_ctrl_assertions (.aclk(aclk),
  .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .options(options), .reset_cause(reset_cause), .power_mode(power_mode),
  .high_rc_clock(high_rc_clock), .com_out(com_out), .seg_out(seg_out), .pump_pin_en(pump_pin_en),
  .pump_enable(pump_enable), .regulator_enable(regulator_enable), .cap_bias_enable(cap_bias_enable),
  .bias_resistor(bias_resistor));
